/* design/chp_port.sv */
/*
 * cpu side access port and background dma engine for the can controller.
 * assumes a synchronous sfr bus (one access per strobe), a can register
 * file with a one-cycle combinational read port, and an internal data ram
 * with a combinational read port and synchronous write.
 */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// - event port read returns interrupt flags
// - event read upper three bits read one
// - flag order wakeup overrun error tx rx
// - event port write goes to command register
// - command byte decoded into command pulses
// - status port bit addressable at d8 to df
// - status read returns controller status bits
// - status write loads dma ram start
// - step mode advances pointer per window access
// - stepping past top clears step mode
// - dma moves one byte per clock
// - dma evaluates length first, tx at start+1
// - 8ah copies descriptor plus data to tx
// - 94h..9dh copies receive buffer to ram
// - dma bit cleared when transfer completes
// - interrupts held off during dma
// - no dma while controller in reset
// - pointer resets to 64h
// - window access hits selected can register
module chp_port
   import chp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   // sfr bus
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_rd,
   input  wire logic       sfr_wr,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       sfr_bit_wr,
   input  wire logic [7:0] sfr_bit_addr,
   input  wire logic       sfr_bit_val,
   output logic      [7:0] sfr_rdata,
   // interrupt hold-off to the cpu's interrupt logic
   output logic            irq_hold,
   // can controller register file
   output logic      [4:0] can_addr,
   output logic            can_rd,
   output logic            can_wr,
   output logic      [7:0] can_wdata,
   input  wire logic [7:0] can_rdata,
   input  wire logic [4:0] can_irq_flags,
   input  wire logic [7:0] can_status,
   input  wire logic       can_reset_req,
   // command pulses to the can controller
   output logic            rx_input_zero_active,
   output logic            rx_input_one_active,
   output logic            wakeup_mode_cmd,
   output logic            sleep_cmd,
   output logic            clear_overrun,
   output logic            release_rx_buffer,
   output logic            abort_transmission,
   output logic            transmission_request,
   // internal data ram
   output logic      [7:0] ram_addr,
   output logic            ram_wr,
   output logic      [7:0] ram_wdata,
   input  wire logic [7:0] ram_rdata
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic [7:0]  ptr;        // can_register_pointer
      logic [7:0]  ram_start;  // dma_ram_start
      logic [7:0]  rdata;      // read data register
      logic [7:0]  cmd;        // command pulses, one cycle
      chp_state_t  st;         // dma engine state
      logic [7:0]  ram_ptr;    // running ram address
      logic [4:0]  buf_ptr;    // running buffer address
      logic [3:0]  left;       // bytes still to move
      logic        is_tx;      // direction of transfer
   } chp_regs_t;

   chp_regs_t r_q;             // registered state
   chp_regs_t r_d;             // next state

   logic       win_acc;        // window access this cycle
   logic [4:0] step_adr;       // pointer address after one step
   logic [3:0] dlc;            // clipped data length code
   logic       rx_sel;         // pointer write selects a receive start

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      r_d      = r_q;
      r_d.cmd  = 8'h00;
      win_acc  = (sfr_rd | sfr_wr) && sfr_addr == CHP_SFR_WINDOW && r_q.st == CHP_IDLE;
      step_adr = r_q.ptr[4:0] + 5'h01;
      rx_sel   = sfr_wdata[4:0] >= CHP_RX_BUF_LO && sfr_wdata[4:0] <= CHP_RX_BUF_HI;
      dlc      = (r_q.is_tx ? ram_rdata[3:0] : can_rdata[3:0]);
      if (dlc > CHP_MAX_DATA) begin
         dlc = CHP_MAX_DATA;
      end
      can_addr  = r_q.ptr[4:0];
      can_rd    = 1'b0;
      can_wr    = 1'b0;
      can_wdata = sfr_wdata;
      ram_addr  = r_q.ram_ptr;
      ram_wr    = 1'b0;
      ram_wdata = can_rdata;
      // cpu reads, registered onto sfr_rdata
      if (sfr_rd) begin
         unique case (sfr_addr)
            CHP_SFR_POINTER: r_d.rdata = r_q.ptr;
            CHP_SFR_WINDOW: begin
               can_rd  = win_acc;
               r_d.rdata = can_rdata;
            end
            CHP_SFR_EVENT: r_d.rdata = {CHP_EVT_RSVD, can_irq_flags};
            CHP_SFR_STATUS: r_d.rdata = can_status;
            default: r_d.rdata = 8'h00;
         endcase
      end
      // cpu writes, ignored while a transfer runs
      if (sfr_wr && r_q.st == CHP_IDLE) begin
         unique case (sfr_addr)
            CHP_SFR_POINTER: begin
               r_d.ptr = sfr_wdata;
               // start only when not in controller reset
               if (sfr_wdata[CHP_PTR_DMA_BIT] && !can_reset_req &&
                   (sfr_wdata[4:0] == CHP_TX_BUF || rx_sel)) begin
                  r_d.st      = CHP_LEN;
                  r_d.is_tx   = sfr_wdata[4:0] == CHP_TX_BUF;
                  r_d.ram_ptr = r_q.ram_start;
                  r_d.buf_ptr = sfr_wdata[4:0];
               end else begin
                  r_d.ptr[CHP_PTR_DMA_BIT] = 1'b0;
               end
            end
            CHP_SFR_WINDOW: can_wr = 1'b1;
            CHP_SFR_EVENT: r_d.cmd = sfr_wdata;
            CHP_SFR_STATUS: r_d.ram_start = sfr_wdata;
            default: r_d.rdata = r_q.rdata;
         endcase
      end
      // single-bit write to the status port loads one bit of ram start
      if (sfr_bit_wr && r_q.st == CHP_IDLE &&
          sfr_bit_addr >= CHP_BIT_STATUS_LO && sfr_bit_addr <= CHP_BIT_STATUS_HI) begin
         r_d.ram_start[sfr_bit_addr[2:0]] = sfr_bit_val;
      end
      // pointer stepping after a window access
      if (win_acc && r_q.ptr[CHP_PTR_STEP_BIT]) begin
         if (r_q.ptr[4:0] == CHP_ADR_MAX) begin
            r_d.ptr[4:0]             = CHP_ADR_WRAP;
            r_d.ptr[CHP_PTR_STEP_BIT] = 1'b0;
         end else begin
            r_d.ptr[4:0] = step_adr;
         end
      end
      // dma engine
      unique case (r_q.st)
         CHP_IDLE: r_d.left = 4'h0;
         CHP_LEN: begin
            // length code: tx from ram start+1, rx from buffer byte 1
            ram_addr = r_q.ram_start + CHP_DLC_OFFSET;
            can_addr = r_q.is_tx ? CHP_TX_BUF + 5'h01 : CHP_RX_BUF_LO + 5'h01;
            can_rd   = !r_q.is_tx;
            // remaining bytes from start offset to end of message
            r_d.left = r_q.is_tx ? CHP_DESC_BYTES + dlc :
                       4'((CHP_RX_BUF_LO + {1'b0, CHP_DESC_BYTES} + {1'b0, dlc})
                          - r_q.buf_ptr);
            r_d.st   = CHP_MOVE;
            // start address already past the end of the message: nothing to move
            if (!r_q.is_tx && r_q.buf_ptr >= CHP_RX_BUF_LO +
                5'({1'b0, CHP_DESC_BYTES}) + 5'({1'b0, dlc})) begin
               r_d.st  = CHP_IDLE;
               r_d.ptr[CHP_PTR_DMA_BIT] = 1'b0;
            end
         end
         CHP_MOVE: begin
            // one byte per clock, both addresses step upward
            can_addr  = r_q.buf_ptr;
            can_rd    = !r_q.is_tx;
            can_wr    = r_q.is_tx;
            can_wdata = ram_rdata;
            ram_wr    = !r_q.is_tx;
            r_d.ram_ptr = r_q.ram_ptr + 8'h01;
            r_d.buf_ptr = r_q.buf_ptr + 5'h01;
            r_d.left    = r_q.left - 4'h1;
            if (r_q.left == 4'h1) begin
               r_d.st = CHP_IDLE;
               r_d.ptr[CHP_PTR_DMA_BIT] = 1'b0;
            end
         end
         default: r_d.st = CHP_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         r_q       <= '0;
         r_q.ptr   <= CHP_PTR_RESET;
         r_q.st    <= CHP_IDLE;
      end else begin
         r_q <= r_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign sfr_rdata            = r_q.rdata;
   assign irq_hold             = r_q.st != CHP_IDLE;
   assign rx_input_zero_active = r_q.cmd[7];
   assign rx_input_one_active  = r_q.cmd[6];
   assign wakeup_mode_cmd      = r_q.cmd[5];
   assign sleep_cmd            = r_q.cmd[4];
   assign clear_overrun        = r_q.cmd[3];
   assign release_rx_buffer    = r_q.cmd[2];
   assign abort_transmission   = r_q.cmd[1];
   assign transmission_request = r_q.cmd[0];

   ////////////////////////////////////////////////////////////////////////////
   // assertions on the sfr side
   // event port read shows the interrupt flags under three high bits
   event_read_a: assert property (@(posedge clk) disable iff (reset)
      sfr_rd && sfr_addr == CHP_SFR_EVENT |=> sfr_rdata == {CHP_EVT_RSVD, $past(can_irq_flags)})
      else $error("event read wrong");
   // command write becomes the pulses bit for bit, with transmission_request low again one cycle later
   cmd_pulse_a: assert property (@(posedge clk) disable iff (reset)
      sfr_wr && sfr_addr == CHP_SFR_EVENT && !irq_hold
      |=> {rx_input_zero_active, rx_input_one_active, wakeup_mode_cmd, sleep_cmd,
           clear_overrun, release_rx_buffer, abort_transmission,
           transmission_request} == $past(sfr_wdata)
          ##1 !transmission_request)
      else $error("command pulse wrong");
   // status port read shows the controller status byte
   status_read_a: assert property (@(posedge clk) disable iff (reset)
      sfr_rd && sfr_addr == CHP_SFR_STATUS |=> sfr_rdata == $past(can_status))
      else $error("status read wrong");
   // status port write loads the dma ram start
   start_load_a: assert property (@(posedge clk) disable iff (reset)
      sfr_wr && sfr_addr == CHP_SFR_STATUS && !irq_hold |=> r_q.ram_start == $past(sfr_wdata))
      else $error("ram start not loaded");
   // window read reaches the selected can register in the same cycle
   win_read_a: assert property (@(posedge clk) disable iff (reset)
      sfr_rd && sfr_addr == CHP_SFR_WINDOW && !irq_hold
      |-> can_rd && can_addr == r_q.ptr[4:0])
      else $error("window read missed");
   // window write reaches the selected can register in the same cycle
   win_write_a: assert property (@(posedge clk) disable iff (reset)
      sfr_wr && sfr_addr == CHP_SFR_WINDOW && !irq_hold
      |-> can_wr && can_addr == r_q.ptr[4:0] && can_wdata == sfr_wdata)
      else $error("window write missed");
   // step mode moves the pointer on by one below the top
   ptr_step_a: assert property (@(posedge clk) disable iff (reset)
      win_acc && r_q.ptr[CHP_PTR_STEP_BIT] && r_q.ptr[4:0] != CHP_ADR_MAX
      |=> r_q.ptr[4:0] == $past(step_adr))
      else $error("pointer did not step");
   // stepping past the top wraps and drops step mode
   ptr_wrap_a: assert property (@(posedge clk) disable iff (reset)
      win_acc && r_q.ptr[CHP_PTR_STEP_BIT] && r_q.ptr[4:0] == CHP_ADR_MAX
      |=> !r_q.ptr[CHP_PTR_STEP_BIT] && r_q.ptr[4:0] == CHP_ADR_WRAP)
      else $error("pointer wrap wrong");

   ////////////////////////////////////////////////////////////////////////////
   // assertions on the dma engine
   // dma bit with the transmit buffer address starts a transmit transfer
   tx_start_a: assert property (@(posedge clk) disable iff (reset)
      sfr_wr && sfr_addr == CHP_SFR_POINTER && !irq_hold && !can_reset_req &&
      sfr_wdata[CHP_PTR_DMA_BIT] && sfr_wdata[4:0] == CHP_TX_BUF
      |=> irq_hold && r_q.is_tx && r_q.ram_ptr == $past(r_q.ram_start))
      else $error("transmit dma not started");
   // dma bit with a receive buffer address starts a receive transfer there
   rx_start_a: assert property (@(posedge clk) disable iff (reset)
      sfr_wr && sfr_addr == CHP_SFR_POINTER && !irq_hold && !can_reset_req &&
      sfr_wdata[CHP_PTR_DMA_BIT] && sfr_wdata[4:0] >= CHP_RX_BUF_LO &&
      sfr_wdata[4:0] <= CHP_RX_BUF_HI
      |=> irq_hold && !r_q.is_tx && r_q.buf_ptr == $past(sfr_wdata[4:0]))
      else $error("receive dma not started");
   // transmit length code is fetched from one above the ram start
   tx_len_a: assert property (@(posedge clk) disable iff (reset)
      r_q.st == CHP_LEN && r_q.is_tx |-> ram_addr == 8'(r_q.ram_start + CHP_DLC_OFFSET))
      else $error("length code address wrong");
   // transmit move copies one ram byte into the buffer per clock
   tx_move_a: assert property (@(posedge clk) disable iff (reset)
      r_q.st == CHP_MOVE && r_q.is_tx
      |-> can_wr && !ram_wr && can_addr == r_q.buf_ptr && can_wdata == ram_rdata)
      else $error("transmit byte not moved");
   // receive move copies one buffer byte into ram per clock
   rx_move_a: assert property (@(posedge clk) disable iff (reset)
      r_q.st == CHP_MOVE && !r_q.is_tx
      |-> ram_wr && !can_wr && ram_addr == r_q.ram_ptr && ram_wdata == can_rdata)
      else $error("receive byte not moved");
   // both running addresses climb by one per byte moved
   step_up_a: assert property (@(posedge clk) disable iff (reset)
      r_q.st == CHP_MOVE
      |=> r_q.ram_ptr == $past(r_q.ram_ptr) + 8'h01 &&
          r_q.buf_ptr == $past(r_q.buf_ptr) + 5'h01)
      else $error("dma addresses did not step");
   // a started transfer ends and drops the dma bit within 11 cycles of the length fetch
   dma_end_a: assert property (@(posedge clk) disable iff (reset)
      r_q.st == CHP_LEN |-> ##[1:11] (r_q.st == CHP_IDLE && !r_q.ptr[CHP_PTR_DMA_BIT]))
      else $error("dma did not finish");
   // controller in reset: the dma bit starts nothing
   no_reset_dma_a: assert property (@(posedge clk) disable iff (reset)
      sfr_wr && sfr_addr == CHP_SFR_POINTER && can_reset_req && !irq_hold |=> !irq_hold)
      else $error("dma started in reset");
   // interrupts stay held off exactly while the dma bit stands
   hold_off_a: assert property (@(posedge clk) disable iff (reset)
      irq_hold == r_q.ptr[CHP_PTR_DMA_BIT])
      else $error("interrupts not held off");
endmodule

/* include/chp_pkg.sv */
/*
 * package for the cpu side access port to the can controller:
 * special function register addresses, field positions, reset values,
 * and the dma engine's state encoding and timing figures.
 * assumes an 8-bit sfr bus and a can register file of 32 byte locations.
 */
package chp_pkg;
   // sfr addresses of the four ports
   localparam logic [7:0] CHP_SFR_POINTER  = 8'hdb;  // can_register_pointer
   localparam logic [7:0] CHP_SFR_WINDOW   = 8'hda;  // can_register_window
   localparam logic [7:0] CHP_SFR_EVENT    = 8'hd9;  // can_event_command_port
   localparam logic [7:0] CHP_SFR_STATUS   = 8'hd8;  // can_status_dma_pointer byte address
   localparam logic [7:0] CHP_BIT_STATUS_LO = 8'hd8; // bit address of status bit 0
   localparam logic [7:0] CHP_BIT_STATUS_HI = 8'hdf; // bit address of status bit 7
   // pointer register fields
   localparam int         CHP_PTR_DMA_BIT  = 7;
   localparam int         CHP_PTR_STEP_BIT = 5;
   localparam logic [7:0] CHP_PTR_RESET    = 8'h64;
   localparam logic [4:0] CHP_ADR_MAX      = 5'h1f;  // highest can register address
   localparam logic [4:0] CHP_ADR_WRAP     = 5'h00;  // address after stepping past the top
   // event read: reserved upper bits read high
   localparam logic [2:0] CHP_EVT_RSVD     = 3'h7;
   // dma buffer addresses
   localparam logic [4:0] CHP_TX_BUF       = 5'h0a;  // 10
   localparam logic [4:0] CHP_RX_BUF_LO    = 5'h14;  // 20
   localparam logic [4:0] CHP_RX_BUF_HI    = 5'h1d;  // 29
   localparam logic [3:0] CHP_DESC_BYTES   = 4'h2;
   localparam logic [3:0] CHP_MAX_DATA     = 4'h8;
   localparam logic [7:0] CHP_DLC_OFFSET   = 8'h01;  // length code sits one above start
   // throughput: 4 bytes per instruction cycle, one byte per clock here
   localparam int         CHP_BYTES_PER_CYCLE = 4;
   // dma engine states
   typedef enum logic [1:0] {
      CHP_IDLE = 2'b00,
      CHP_LEN  = 2'b01,
      CHP_MOVE = 2'b10
   } chp_state_t;
endpackage

/* sim/chp_far_model.sv */
/* far side model: can controller register file and internal data ram.
   assumes combinational reads and writes taken on the rising edge. */
`timescale 1ns/1ps
module chp_far_model (
   input  wire logic       clk,
   input  wire logic [4:0] can_addr,
   input  wire logic       can_wr,
   input  wire logic [7:0] can_wdata,
   output logic      [7:0] can_rdata,
   input  wire logic [7:0] ram_addr,
   input  wire logic       ram_wr,
   input  wire logic [7:0] ram_wdata,
   output logic      [7:0] ram_rdata
);
   logic [7:0] can_mem [32];  // can controller registers
   logic [7:0] ram_mem [256]; // internal data ram
   ////////////////////////////////////////////////////////////////////////////////
   // reads settle combinationally from the addressed byte
   assign can_rdata = can_mem[can_addr];
   assign ram_rdata = ram_mem[ram_addr];
   // writes land on the clock edge
   always @(posedge clk) begin
      if (can_wr) begin
         can_mem[can_addr] <= can_wdata;
      end
      if (ram_wr) begin
         ram_mem[ram_addr] <= ram_wdata;
      end
   end
endmodule

/* sim/can_host_port_and_dma_tb.sv */
/* self-checking bench for the can host port: random and corner traffic
   on the sfr bus. assumes chp_pkg, chp_port and the far model. */
`timescale 1ns/1ps
module can_host_port_and_dma_tb
   import chp_pkg::*;
;
   logic       clk = 1'b0;
   logic       reset, sfr_rd, sfr_wr, sfr_bit_wr, sfr_bit_val, can_reset_req;
   logic       irq_hold, can_wr, ram_wr;
   logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata, can_status;
   logic [7:0] can_wdata, can_rdata, ram_addr, ram_wdata, ram_rdata, cmd_v;
   logic [4:0] can_addr, can_irq_flags;
   int         num_errors = 0;
   int         n_tests = 0;
   int         cyc = 0;
   ////////////////////////////////////////////////////////////////////////////////
   chp_port dut_u (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
      .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
      .sfr_bit_addr(sfr_bit_addr), .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata),
      .irq_hold(irq_hold), .can_addr(can_addr), .can_rd(), .can_wr(can_wr),
      .can_wdata(can_wdata), .can_rdata(can_rdata), .can_irq_flags(can_irq_flags),
      .can_status(can_status), .can_reset_req(can_reset_req),
      .rx_input_zero_active(cmd_v[7]), .rx_input_one_active(cmd_v[6]),
      .wakeup_mode_cmd(cmd_v[5]), .sleep_cmd(cmd_v[4]), .clear_overrun(cmd_v[3]),
      .release_rx_buffer(cmd_v[2]), .abort_transmission(cmd_v[1]),
      .transmission_request(cmd_v[0]), .ram_addr(ram_addr), .ram_wr(ram_wr),
      .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));
   chp_far_model far_u (.clk(clk), .can_addr(can_addr), .can_wr(can_wr),
      .can_wdata(can_wdata), .can_rdata(can_rdata), .ram_addr(ram_addr),
      .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));
   ////////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         test_done();
      end
   end
   // compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // bus cycles: strobe held over exactly one taken edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge clk) #1;
      sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk) #1;
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge clk) #1;
      sfr_rd = 1'b0;
      d = sfr_rdata;
   endtask
   task automatic bw(input int j, input logic v);
      @(posedge clk) #1;
      sfr_bit_addr = 8'(CHP_BIT_STATUS_LO + j);
      sfr_bit_val = v;
      sfr_bit_wr = 1'b1;
      @(posedge clk) #1;
      sfr_bit_wr = 1'b0;
   endtask
   // no port access while the transfer runs, bounded wait
   task automatic wait_dma(output int cnt);
      cnt = 0;
      while (irq_hold === 1'b1 && cnt < 40) begin
         @(posedge clk) #1;
         cnt++;
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] d, st, v;
      logic [3:0] dl;
      int         k, n, mn, cnt, e;
      {reset, sfr_rd, sfr_wr, sfr_bit_wr, sfr_bit_val, can_reset_req} = 6'h20;
      {sfr_addr, sfr_wdata, sfr_bit_addr, can_status} = '0;
      can_irq_flags = '0;
      void'($urandom(32'h8443));
      repeat (5) @(posedge clk);
      #1 reset = 1'b0;
      // reset value and an unmapped place
      rd(CHP_SFR_POINTER, d);
      chk(d, CHP_PTR_RESET);
      rd(8'h00, d);
      chk(d, 8'h00);
      $display("test reset done");
      // event, status and command ports
      for (k = 0; k < 6; k++) begin
         can_irq_flags = 5'($urandom);
         can_status = 8'($urandom);
         v = (k == 0) ? 8'hff : 8'($urandom);
         rd(CHP_SFR_EVENT, d);
         chk(d, {CHP_EVT_RSVD, can_irq_flags});
         rd(CHP_SFR_STATUS, d);
         chk(d, can_status);
         wr(CHP_SFR_EVENT, v);
         chk(cmd_v, v);
         @(posedge clk) #1;
         chk(cmd_v, 8'h00);
      end
      $display("test ports done");
      // window with stepping across the top
      v = 8'($urandom);
      wr(CHP_SFR_POINTER, 8'h3e);
      wr(CHP_SFR_WINDOW, v);
      wr(CHP_SFR_WINDOW, ~v);
      chk(far_u.can_mem[30], v);
      chk(far_u.can_mem[31], ~v);
      rd(CHP_SFR_POINTER, d);
      chk(d, 8'h00);
      far_u.can_mem[0] = 8'($urandom);
      rd(CHP_SFR_WINDOW, d);
      chk(d, far_u.can_mem[0]);
      $display("test window done");
      // transmit transfers, every length code including clipped ones
      for (n = 0; n < 16; n++) begin
         st = 8'($urandom);
         mn = (n > 8) ? 8 : n;
         for (k = 0; k < 11; k++) begin
            far_u.ram_mem[8'(st + k)] = 8'($urandom);
            far_u.can_mem[10 + k] = ~far_u.ram_mem[8'(st + k)];
         end
         far_u.ram_mem[8'(st + 1)][3:0] = 4'(n);
         wr(CHP_SFR_STATUS, st);
         wr(CHP_SFR_POINTER, 8'h8a);
         chk(irq_hold, 1'b1);
         wait_dma(cnt);
         chk(8'(cnt == mn + 3), 8'h01);
         for (k = 0; k < mn + 3; k++) begin
            v = far_u.ram_mem[8'(st + k)];
            chk(far_u.can_mem[10 + k], (k < mn + 2) ? v : ~v);
         end
         rd(CHP_SFR_POINTER, d);
         chk(d, 8'h0a);
      end
      $display("test transmit done");
      // receive transfers from every start address, ram start set bitwise
      for (n = 20; n < 30; n++) begin
         st = 8'($urandom);
         dl = (n == 20) ? 4'h8 : 4'($urandom);
         for (k = 20; k < 30; k++) begin
            far_u.can_mem[k] = (k == 21) ? {4'($urandom), dl} : 8'($urandom);
            far_u.ram_mem[8'(st + k - 20)] = ~far_u.can_mem[k];
         end
         mn = 22 + ((dl > 4'h8) ? 8 : int'(dl)) - n;
         e = (mn < 0) ? 0 : mn;
         wr(CHP_SFR_STATUS, ~st);
         for (k = 0; k < 8; k++) begin
            bw(k, st[k]);
         end
         wr(CHP_SFR_POINTER, 8'(8'h80 + n));
         wait_dma(cnt);
         chk(8'(cnt == e + 1), 8'h01);
         for (k = 0; k < e; k++) begin
            chk(far_u.ram_mem[8'(st + k)], far_u.can_mem[n + k]);
         end
         if (e < 10) begin
            chk(far_u.ram_mem[8'(st + e)], ~far_u.can_mem[20 + e]);
         end
         rd(CHP_SFR_POINTER, d);
         chk(d, 8'(n));
      end
      $display("test receive done");
      // controller in reset: no transfer
      can_reset_req = 1'b1;
      far_u.can_mem[10] = 8'h5a;
      far_u.ram_mem[0] = 8'ha5;
      wr(CHP_SFR_STATUS, 8'h00);
      wr(CHP_SFR_POINTER, 8'h8a);
      chk(irq_hold, 1'b0);
      rd(CHP_SFR_POINTER, d);
      chk(d, 8'h0a);
      chk(far_u.can_mem[10], 8'h5a);
      can_reset_req = 1'b0;
      $display("test reset request done");
      test_done();
   end
endmodule
